// ### pkg/dfa_defines.svh
// register map, field positions and numeric constants of the datapath
`ifndef DFA_DEFINES_SVH
`define DFA_DEFINES_SVH

// byte addresses on the register bus
`define DFA_ADDR_OPA       8'h00
`define DFA_ADDR_OPB       8'h04
`define DFA_ADDR_OPC       8'h08
`define DFA_ADDR_CMD       8'h0C
`define DFA_ADDR_RES0      8'h10
`define DFA_ADDR_RES1      8'h14
`define DFA_ADDR_RES2      8'h18
`define DFA_ADDR_FLAGS     8'h1C

// flag register layout and command field
`define DFA_FLG_CARRY      0
`define DFA_FLG_OVF        1
`define DFA_FLG_CC         3:2
`define DFA_FLG_BUSY       4
`define DFA_CMD_FIELD      4:0

// condition codes
`define DFA_CC_GREATER     2'h0
`define DFA_COND_LESS_THAN 2'h1
`define DFA_CC_EQUAL       2'h2
`define DFA_CC_RESET       2'h2

// word fields, msb of the word is the documented bit 0
`define DFA_SIGN           15
`define DFA_EXP_HI         14
`define DFA_EXP_LO         6
`define DFA_FRAC_HI        5
`define DFA_HI_BYTE        15:8
`define DFA_LO_BYTE        7:0
`define DFA_BYTE_SEL       0
`define DFA_WORD_ADDR      15:1

// floating point numbers and integer result limits
`define DFA_EXP_BIAS       11'sh100
`define DFA_EXP_MAX        11'sh1FF
`define DFA_HIDDEN         6'h16
`define DFA_HIDDEN_EXP     11'sh016
`define DFA_XLEAD          6'h26
`define DFA_XLEAD_EXP      11'sh026
`define DFA_ALIGN_MAX      9'h018
`define DFA_FIX_TOP        6'h1F
`define DFA_FIX_MAXEXP     11'sh00F
`define DFA_FIX_MINEXP     11'sh7FF
`define DFA_INT_MAX        17'h0_7FFF
`define DFA_INT_MIN_MAG    17'h0_8000
`define DFA_QUO_MAX        32'h0000_7FFF
`define DFA_QUO_MIN_MAG    32'h0000_8000

`endif

// ### pkg/dfa_pkg.sv
// shared types of the data-format arithmetic datapath
package dfa_pkg;

	// operation codes written to the command register
	typedef enum logic [4:0] {
		OP_UNSIGNED_ADD      = 5'h00,
		OP_UNSIGNED_SUBTRACT = 5'h01,
		OP_UNSIGNED_MULTIPLY = 5'h02,
		OP_UNSIGNED_DIVIDE   = 5'h03,
		OP_UNSIGNED_COMPARE  = 5'h04,
		OP_SIGNED_ADD        = 5'h05,
		OP_SIGNED_SUBTRACT   = 5'h06,
		OP_SIGNED_MULTIPLY   = 5'h07,
		OP_SIGNED_DIVIDE     = 5'h08,
		OP_WIDENING_MULTIPLY = 5'h09,
		OP_WIDE_DIVIDEND_DIV = 5'h0A,
		OP_FLOAT_SUM         = 5'h0B,
		OP_FLOAT_DIFFERENCE  = 5'h0C,
		OP_FLOAT_PRODUCT     = 5'h0D,
		OP_FLOAT_QUOTIENT    = 5'h0E,
		OP_FLOAT_TO_INT_TRNC = 5'h0F,
		OP_FLOAT_TO_INT_RND  = 5'h10,
		OP_EXT_FLOAT_NORM    = 5'h11,
		OP_BYTE_FETCH        = 5'h12,
		OP_BYTE_STORE        = 5'h13
	} dfa_op_e;

	// sequencer states
	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_DIVIDE = 1'b1
	} dfa_state_e;

endpackage

// ### hw/dfa_divider.sv
// restoring unsigned divider, one quotient bit per clock
module dfa_divider #(
	parameter int DW = 48,
	parameter int VW = 24
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic [DW-1:0] num,
	input  wire logic [VW-1:0] den,
	output logic               done,
	output logic [DW-1:0]      quo,
	output logic [VW-1:0]      rem
);
	localparam int CW = $clog2(DW + 1);

	logic [VW-1:0] part;
	logic [VW-1:0] dsr;
	logic [CW-1:0] cnt;
	logic          busy;
	logic [VW:0]   shifted;
	logic          fits;

	// next partial remainder; zero divisor yields all-ones quotient
	assign shifted = {part, quo[DW-1]};
	assign fits = shifted >= {1'b0, dsr};
	assign rem = part;

	// one trial subtraction per cycle, done pulses after the last
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			part <= '0;
			dsr <= '0;
			quo <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			part <= '0;
			dsr <= den;
			quo <= num;
			cnt <= CW'(DW);
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			part <= fits ? VW'(shifted - {1'b0, dsr}) : VW'(shifted);
			quo <= {quo[DW-2:0], fits};
			cnt <= cnt - 1'b1;
			busy <= cnt != CW'(1);
			done <= cnt == CW'(1);
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// ### hw/dfa_float_unpack.sv
// splits a floating point value into sign, biased exponent and mantissa
`include "dfa_defines.svh"
module dfa_float_unpack #(
	parameter int FW = 22
) (
	input  wire logic [15:0]   word_hi,
	input  wire logic [FW-7:0] word_lo,
	output logic               sign,
	output logic [8:0]         expo,
	output logic [FW:0]        mant,
	output logic               zero
);
	// only the all-zero pattern is zero; the hidden one is dropped for it
	assign zero = ~|{word_hi, word_lo};
	assign sign = word_hi[`DFA_SIGN];
	assign expo = word_hi[`DFA_EXP_HI:`DFA_EXP_LO];
	assign mant = zero ? '0 : {1'b1, word_hi[`DFA_FRAC_HI:0], word_lo};
endmodule

// ### hw/dfa_datapath.sv
// arithmetic and data-format datapath with its APB register file
`include "dfa_defines.svh"
// How it works
// - ascending byte addresses reach the high byte before the low byte
// - unsigned arithmetic treats a word as 0 to 65535
// - unsigned add and subtract leave overflow alone, else match signed
// - unsigned add carry is the carry out of the top bit
// - subtract adds the two's complement; carry set unless B above A
// - unsigned multiply never overflows; carry flags a nonzero high word
// - unsigned divide flags overflow for a too-wide quotient, kept modulo
// - condition code of unsigned results reads the value as signed
// - single words are two's complement with the top bit as sign
// - signed add and subtract flag overflow into sign, carry also set
// - signed multiply and divide leave carry, flag overflow beyond 16 bits
// - doublewords join two words, sign in the more significant word
// - widening multiply clears overflow; carry flags a wide product
// - float word holds sign, nine exponent bits, then fraction
// - float is sign and magnitude with an implied leading one
// - float zero is all zero bits and ignores the implied one
// - float exponent carries a bias of 256
// - float arithmetic and fix flag overflow; fix uses carry for inexact
// - extended float appends sixteen fraction bits as a third word
// - multiword results put the least significant word last, except unsigned multiply which puts it first
module dfa_datapath (
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	logic [15:0]          opa, opb, opc, res0, res1, res2;
	logic                 carry, ovf, addr_ok, apb_wr, start;
	logic [1:0]           cc;
	logic [31:0]          rd_mux, rd_mux_q;
	dfa_pkg::dfa_state_e  state;
	dfa_pkg::dfa_op_e     cmd_op, pend_op;
	logic                 q_neg, r_neg, den_zero, fq_sign;
	logic signed [10:0]   fq_exp;
	// operand views
	logic                 sa, sb, za, zb, xs, xz;
	logic [8:0]           ea, eb, xe;
	logic [22:0]          ma, mb;
	logic [38:0]          xm;
	// next values from the single-cycle operations
	logic [15:0]          next_res0, next_res1, next_res2;
	logic                 next_carry, next_ovf, next_div, next_q_neg;
	logic                 next_r_neg, next_den_zero, next_fq_sign;
	logic [1:0]           next_cc;
	logic signed [10:0]   next_fq_exp;
	logic [47:0]          div_num, div_q;
	logic [23:0]          div_den, div_r;
	logic                 div_done;
	// datapath temporaries
	logic [16:0]          sum17, dif17, fmag;
	logic [31:0]          uprod, fval;
	logic signed [31:0]   sprod;
	logic                 swap, sub_eff, rsign, frnd, finx;
	logic [8:0]           be, ediff;
	logic [22:0]          bm, sm, nm;
	logic [24:0]          al, s25;
	logic [5:0]           lp, fsh;
	logic signed [10:0]   ne, ft;
	logic [32:0]          pk;
	logic [45:0]          fp;
	logic [37:0]          xn;
	// divide finishing values
	logic [15:0]          fin_res0, fin_res1;
	logic                 fin_ovf;
	logic [1:0]           fin_cc;
	logic [31:0]          qmag;
	logic [32:0]          fin_pk;

	// condition code from a result read as a signed word
	function automatic logic [1:0] cc_of(input logic [15:0] v);
		if (v == 16'h0000)
			return `DFA_CC_EQUAL;
		return v[`DFA_SIGN] ? `DFA_COND_LESS_THAN : `DFA_CC_GREATER;
	endfunction

	// condition code of a float from its sign and zero state
	function automatic logic [1:0] fcc(input logic s, input logic z);
		if (z)
			return `DFA_CC_EQUAL;
		return s ? `DFA_COND_LESS_THAN : `DFA_CC_GREATER;
	endfunction

	// index of the highest set bit
	function automatic logic [5:0] lead_one(input logic [63:0] v);
		logic [5:0] p;
		p = 6'h00;
		for (int i = 0; i < 64; i++)
			if (v[i])
				p = 6'(i);
		return p;
	endfunction

	// packs sign, biased exponent and mantissa, top bit is exponent range
	function automatic logic [32:0] fpack(input logic s,
		input logic signed [10:0] e, input logic [22:0] m);
		logic bad;
		bad = (e < 11'sh000) || (e > `DFA_EXP_MAX);
		return {bad, s, e[8:0], m[21:0]};
	endfunction

	// standard operands from a:b and c:res2, extended operand from a, b, c
	dfa_float_unpack #(.FW(22)) u_unpack_a (
		.word_hi (opa),
		.word_lo (opb),
		.sign    (sa),
		.expo    (ea),
		.mant    (ma),
		.zero    (za)
	);
	dfa_float_unpack #(.FW(22)) u_unpack_b (
		.word_hi (opc),
		.word_lo (res2),
		.sign    (sb),
		.expo    (eb),
		.mant    (mb),
		.zero    (zb)
	);
	dfa_float_unpack #(.FW(38)) u_unpack_x (
		.word_hi (opa),
		.word_lo ({opb, opc}),
		.sign    (xs),
		.expo    (xe),
		.mant    (xm),
		.zero    (xz)
	);

	// shared divider serves integer and float quotients
	dfa_divider #(.DW(48), .VW(24)) u_divider (
		.clk   (SYS_CLK),
		.rst   (RESET),
		.start (start & next_div),
		.num   (div_num),
		.den   (div_den),
		.done  (div_done),
		.quo   (div_q),
		.rem   (div_r)
	);

	// zero-wait slave; error only for unmapped addresses
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;
	assign PRDATA = rd_mux_q;
	assign apb_wr = PSEL & PENABLE & PWRITE & addr_ok;
	assign cmd_op = dfa_pkg::dfa_op_e'(PWDATA[`DFA_CMD_FIELD]);
	// commands while a divide runs are dropped, not queued
	assign start = apb_wr && PADDR == `DFA_ADDR_CMD &&
		state == dfa_pkg::ST_IDLE;

	// read decode, narrow registers sit in the low bits
	always_comb begin
		addr_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (PADDR)
			`DFA_ADDR_OPA:   rd_mux[15:0] = opa;
			`DFA_ADDR_OPB:   rd_mux[15:0] = opb;
			`DFA_ADDR_OPC:   rd_mux[15:0] = opc;
			`DFA_ADDR_CMD:   rd_mux[`DFA_CMD_FIELD] = pend_op;
			`DFA_ADDR_RES0:  rd_mux[15:0] = res0;
			`DFA_ADDR_RES1:  rd_mux[15:0] = res1;
			`DFA_ADDR_RES2:  rd_mux[15:0] = res2;
			`DFA_ADDR_FLAGS: begin
				rd_mux[`DFA_FLG_CARRY] = carry;
				rd_mux[`DFA_FLG_OVF] = ovf;
				rd_mux[`DFA_FLG_CC] = cc;
				rd_mux[`DFA_FLG_BUSY] = state != dfa_pkg::ST_IDLE;
			end
			default:         addr_ok = 1'b0;
		endcase
	end

	// read data captured in the setup cycle so it stands through access
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			rd_mux_q <= 32'h0000_0000;
		else if (PSEL & ~PENABLE & ~PWRITE)
			rd_mux_q <= rd_mux;
	end

	// operand registers
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			opa <= 16'h0000;
			opb <= 16'h0000;
			opc <= 16'h0000;
		end else if (apb_wr && state == dfa_pkg::ST_IDLE) begin
			if (PADDR == `DFA_ADDR_OPA)
				opa <= PWDATA[15:0];
			if (PADDR == `DFA_ADDR_OPB)
				opb <= PWDATA[15:0];
			if (PADDR == `DFA_ADDR_OPC)
				opc <= PWDATA[15:0];
		end
	end

	// single-cycle operations and divide set-up
	always_comb begin
		next_res0 = res0;
		next_res1 = res1;
		next_res2 = res2;
		next_carry = carry;
		next_ovf = ovf;
		next_cc = cc;
		next_div = 1'b0;
		next_q_neg = q_neg;
		next_r_neg = r_neg;
		next_den_zero = den_zero;
		next_fq_sign = fq_sign;
		next_fq_exp = fq_exp;
		div_num = 48'h0000_0000_0000;
		div_den = 24'h00_0000;
		sum17 = {1'b0, opa} + {1'b0, opb};
		dif17 = {1'b0, opa} + {1'b0, ~opb} + 17'h0_0001;
		uprod = opa * opb;
		sprod = $signed(opa) * $signed(opb);
		sub_eff = sa ^ sb ^ (cmd_op == dfa_pkg::OP_FLOAT_DIFFERENCE);
		swap = {eb, mb} > {ea, ma};
		be = swap ? eb : ea;
		bm = swap ? mb : ma;
		sm = swap ? ma : mb;
		rsign = swap ? sb ^ (cmd_op == dfa_pkg::OP_FLOAT_DIFFERENCE) : sa;
		ediff = swap ? eb - ea : ea - eb;
		al = (ediff > `DFA_ALIGN_MAX) ? 25'h000_0000 : {2'b00, sm} >> ediff;
		s25 = sub_eff ? {2'b00, bm} - al : {2'b00, bm} + al;
		lp = lead_one({39'h0, s25});
		nm = (lp > `DFA_HIDDEN) ? s25[23:1] : 23'(s25 << (`DFA_HIDDEN - lp));
		ne = $signed({2'b00, be}) + $signed({5'h00, lp}) - `DFA_HIDDEN_EXP;
		pk = fpack(rsign, ne, nm);
		fp = ma * mb;
		ft = $signed({2'b00, ea}) - `DFA_EXP_BIAS;
		fval = {ma, 9'h000};
		fsh = `DFA_FIX_TOP - ft[5:0];
		fmag = 17'(fval >> fsh);
		frnd = fval[5'(fsh - 6'h01)];
		finx = |(fval & ~(32'hFFFF_FFFF << fsh));
		xn = 38'(xm[37:0] << (`DFA_XLEAD - lead_one({26'h0, xm[37:0]})));
		case (cmd_op)
			dfa_pkg::OP_UNSIGNED_ADD, dfa_pkg::OP_SIGNED_ADD: begin
				next_res0 = sum17[15:0];
				next_carry = sum17[16];
				next_cc = cc_of(sum17[15:0]);
				if (cmd_op == dfa_pkg::OP_SIGNED_ADD)
					next_ovf = (opa[`DFA_SIGN] == opb[`DFA_SIGN]) &&
						(sum17[`DFA_SIGN] != opa[`DFA_SIGN]);
			end
			dfa_pkg::OP_UNSIGNED_SUBTRACT, dfa_pkg::OP_SIGNED_SUBTRACT: begin
				next_res0 = dif17[15:0];
				next_carry = dif17[16];
				next_cc = cc_of(dif17[15:0]);
				if (cmd_op == dfa_pkg::OP_SIGNED_SUBTRACT)
					next_ovf = (opa[`DFA_SIGN] != opb[`DFA_SIGN]) &&
						(dif17[`DFA_SIGN] != opa[`DFA_SIGN]);
			end
			dfa_pkg::OP_UNSIGNED_COMPARE:
				next_cc = (opa < opb) ? `DFA_COND_LESS_THAN :
					(opa == opb) ? `DFA_CC_EQUAL : `DFA_CC_GREATER;
			dfa_pkg::OP_UNSIGNED_MULTIPLY: begin
				next_res0 = uprod[15:0];
				next_res1 = uprod[31:16];
				next_carry = |uprod[31:16];
				next_cc = cc_of(uprod[15:0]);
			end
			dfa_pkg::OP_SIGNED_MULTIPLY: begin
				next_res0 = sprod[15:0];
				next_ovf = sprod != 32'($signed(sprod[15:0]));
				next_cc = cc_of(sprod[15:0]);
			end
			dfa_pkg::OP_WIDENING_MULTIPLY: begin
				next_res0 = sprod[31:16];
				next_res1 = sprod[15:0];
				next_ovf = 1'b0;
				next_carry = sprod != 32'($signed(sprod[15:0]));
				next_cc = (sprod == 32'h0000_0000) ? `DFA_CC_EQUAL :
					cc_of(sprod[31:16]);
			end
			dfa_pkg::OP_UNSIGNED_DIVIDE: begin
				next_div = 1'b1;
				div_num = {16'h0000, opa, opb};
				div_den = {8'h00, opc};
				next_den_zero = opc == 16'h0000;
			end
			dfa_pkg::OP_SIGNED_DIVIDE: begin
				next_div = 1'b1;
				div_num = {32'h0000_0000,
					opa[`DFA_SIGN] ? 16'(-opa) : opa};
				div_den = {8'h00, opb[`DFA_SIGN] ? 16'(-opb) : opb};
				next_den_zero = opb == 16'h0000;
				next_q_neg = opa[`DFA_SIGN] ^ opb[`DFA_SIGN];
				next_r_neg = opa[`DFA_SIGN];
			end
			dfa_pkg::OP_WIDE_DIVIDEND_DIV: begin
				next_div = 1'b1;
				div_num = {16'h0000, opa[`DFA_SIGN] ?
					32'(-{opa, opb}) : {opa, opb}};
				div_den = {8'h00, opc[`DFA_SIGN] ? 16'(-opc) : opc};
				next_den_zero = opc == 16'h0000;
				next_q_neg = opa[`DFA_SIGN] ^ opc[`DFA_SIGN];
				next_r_neg = opa[`DFA_SIGN];
			end
			dfa_pkg::OP_FLOAT_QUOTIENT: begin
				next_div = 1'b1;
				div_num = {2'b00, ma, 23'h00_0000};
				div_den = {1'b0, mb};
				next_den_zero = zb;
				next_fq_sign = sa ^ sb;
				next_fq_exp = $signed({2'b00, ea}) - $signed({2'b00, eb}) +
					`DFA_EXP_BIAS;
			end
			dfa_pkg::OP_FLOAT_SUM, dfa_pkg::OP_FLOAT_DIFFERENCE: begin
				next_res0 = pk[31:16];
				next_res1 = pk[15:0];
				next_ovf = pk[32];
				next_cc = fcc(rsign, 1'b0);
				if (s25 == 25'h000_0000) begin
					next_res0 = 16'h0000;
					next_res1 = 16'h0000;
					next_ovf = 1'b0;
					next_cc = `DFA_CC_EQUAL;
				end
			end
			dfa_pkg::OP_FLOAT_PRODUCT: begin
				ne = $signed({2'b00, ea}) + $signed({2'b00, eb}) -
					`DFA_EXP_BIAS + $signed({10'h000, fp[45]});
				pk = fpack(sa ^ sb, ne, fp[45] ? fp[45:23] : fp[44:22]);
				next_res0 = (za | zb) ? 16'h0000 : pk[31:16];
				next_res1 = (za | zb) ? 16'h0000 : pk[15:0];
				next_ovf = ~(za | zb) & pk[32];
				next_cc = fcc(sa ^ sb, za | zb);
			end
			dfa_pkg::OP_FLOAT_TO_INT_TRNC, dfa_pkg::OP_FLOAT_TO_INT_RND: begin
				if (ft < `DFA_FIX_MINEXP) begin
					fmag = 17'h0_0000;
					frnd = 1'b0;
					finx = 1'b1;
				end
				if (cmd_op == dfa_pkg::OP_FLOAT_TO_INT_RND)
					fmag = fmag + {16'h0000, frnd};
				if (za) begin
					fmag = 17'h0_0000;
					finx = 1'b0;
				end
				next_ovf = (ft > `DFA_FIX_MAXEXP && !za) || fmag >
					(sa ? `DFA_INT_MIN_MAG : `DFA_INT_MAX);
				next_carry = finx;
				next_res0 = sa ? 16'(-fmag) : fmag[15:0];
				next_cc = cc_of(next_res0);
			end
			dfa_pkg::OP_EXT_FLOAT_NORM: begin
				ne = $signed({2'b00, xe}) +
					$signed({5'h00, lead_one({26'h0, xm[37:0]})}) -
					`DFA_XLEAD_EXP;
				next_res0 = {xs, ne[8:0], xn[37:32]};
				next_res1 = xn[31:16];
				next_res2 = xn[15:0];
				next_ovf = (ne < 11'sh000) || (ne > `DFA_EXP_MAX);
				next_cc = fcc(xs, 1'b0);
				if (xm[37:0] == 38'h0 || xz) begin
					next_res0 = 16'h0000;
					next_res1 = 16'h0000;
					next_res2 = 16'h0000;
					next_ovf = 1'b0;
					next_cc = `DFA_CC_EQUAL;
				end
			end
			dfa_pkg::OP_BYTE_FETCH: begin
				next_res0 = {8'h00, opa[`DFA_BYTE_SEL] ?
					opb[`DFA_LO_BYTE] : opb[`DFA_HI_BYTE]};
				next_res1 = {1'b0, opa[`DFA_WORD_ADDR]};
			end
			dfa_pkg::OP_BYTE_STORE: begin
				next_res0 = opa[`DFA_BYTE_SEL] ?
					{opb[`DFA_HI_BYTE], opc[`DFA_LO_BYTE]} :
					{opc[`DFA_LO_BYTE], opb[`DFA_LO_BYTE]};
				next_res1 = {1'b0, opa[`DFA_WORD_ADDR]};
			end
			default: next_div = 1'b0;
		endcase
	end

	// divide results; carry is never touched here
	always_comb begin
		fin_res0 = res0;
		fin_res1 = res1;
		fin_ovf = ovf;
		fin_cc = cc;
		qmag = div_q[31:0];
		fin_pk = fpack(fq_sign, div_q[23] ? fq_exp : fq_exp - 11'sh001,
			div_q[23] ? div_q[23:1] : div_q[22:0]);
		case (pend_op)
			dfa_pkg::OP_UNSIGNED_DIVIDE: begin
				fin_res0 = div_q[15:0];
				fin_res1 = div_r[15:0];
				fin_ovf = den_zero | (|div_q[47:16]);
				fin_cc = cc_of(div_q[15:0]);
			end
			dfa_pkg::OP_SIGNED_DIVIDE, dfa_pkg::OP_WIDE_DIVIDEND_DIV: begin
				fin_res0 = q_neg ? 16'(-qmag) : qmag[15:0];
				fin_res1 = r_neg ? 16'(-div_r[15:0]) : div_r[15:0];
				fin_ovf = den_zero | (qmag > (q_neg ? `DFA_QUO_MIN_MAG :
					`DFA_QUO_MAX));
				fin_cc = cc_of(fin_res0);
			end
			dfa_pkg::OP_FLOAT_QUOTIENT: begin
				fin_res0 = fin_pk[31:16];
				fin_res1 = fin_pk[15:0];
				fin_ovf = den_zero | fin_pk[32];
				fin_cc = fcc(fq_sign, 1'b0);
				if (!den_zero && div_q == 48'h0000_0000_0000) begin
					fin_res0 = 16'h0000;
					fin_res1 = 16'h0000;
					fin_cc = `DFA_CC_EQUAL;
				end
			end
			default: fin_ovf = ovf;
		endcase
	end

	// sequencer: everything is one cycle except the divides
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			state <= dfa_pkg::ST_IDLE;
		else
			case (state)
				dfa_pkg::ST_IDLE:
					if (start && next_div)
						state <= dfa_pkg::ST_DIVIDE;
				dfa_pkg::ST_DIVIDE:
					if (div_done)
						state <= dfa_pkg::ST_IDLE;
				default: state <= dfa_pkg::ST_IDLE;
			endcase
	end

	// divide context held while the divider runs
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			pend_op <= dfa_pkg::OP_UNSIGNED_ADD;
			q_neg <= 1'b0;
			r_neg <= 1'b0;
			den_zero <= 1'b0;
			fq_sign <= 1'b0;
			fq_exp <= 11'sh000;
		end else if (start) begin
			pend_op <= cmd_op;
			q_neg <= next_q_neg;
			r_neg <= next_r_neg;
			den_zero <= next_den_zero;
			fq_sign <= next_fq_sign;
			fq_exp <= next_fq_exp;
		end
	end

	// result words and indicators; software may preset the indicators
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			res0 <= 16'h0000;
			res1 <= 16'h0000;
			res2 <= 16'h0000;
			carry <= 1'b0;
			ovf <= 1'b0;
			cc <= `DFA_CC_RESET;
		end else if (start) begin
			res0 <= next_res0;
			res1 <= next_res1;
			res2 <= next_res2;
			carry <= next_carry;
			ovf <= next_ovf;
			cc <= next_cc;
		end else if (state == dfa_pkg::ST_DIVIDE && div_done) begin
			res0 <= fin_res0;
			res1 <= fin_res1;
			ovf <= fin_ovf;
			cc <= fin_cc;
		end else if (apb_wr && state == dfa_pkg::ST_IDLE) begin
			if (PADDR == `DFA_ADDR_RES2)
				res2 <= PWDATA[15:0];
			if (PADDR == `DFA_ADDR_FLAGS) begin
				carry <= PWDATA[`DFA_FLG_CARRY];
				ovf <= PWDATA[`DFA_FLG_OVF];
				cc <= PWDATA[`DFA_FLG_CC];
			end
		end
	end
endmodule

// ### sim/dfa_datapath_monitor.sv
// port-level protocol and format checks for the datapath
`include "dfa_defines.svh"
module dfa_datapath_monitor (
	input wire logic        SYS_CLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	logic acc;
	logic rd;
	logic map;
	// access decode; unaligned low addresses left unjudged on purpose
	assign acc = PSEL && PENABLE;
	assign rd = acc && !PWRITE;
	assign map = PADDR <= 8'h1C && PADDR[1:0] == 2'h0;
	a_ready_always: assert property (acc |-> PREADY)
		else $error("access without ready");
	a_err_in_access: assert property (PSLVERR |-> acc)
		else $error("error outside access");
	a_err_unmapped: assert property (acc && PADDR > 8'h1C |-> PSLVERR)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (acc && map |-> !PSLVERR)
		else $error("mapped access refused");
	a_err_once: assert property (PSLVERR |=> !PSLVERR)
		else $error("error held past access");
	a_upper_zero: assert property (rd |-> PRDATA[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_rdata_hold: assert property
		(!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
		else $error("read data moved outside setup");
	a_unmapped_zero: assert property (rd && PSLVERR |-> PRDATA == 32'h0)
		else $error("unmapped read data not zero");
	a_flag_form: assert property (rd && PADDR == `DFA_ADDR_FLAGS |->
		PRDATA[15:5] == 11'h000 && PRDATA[3:2] != 2'h3)
		else $error("bad flag word");
	// main traffic kinds
	c_cmd: cover property (acc && PWRITE && PADDR == `DFA_ADDR_CMD);
	c_err: cover property (PSLVERR);
	c_flags: cover property (rd && PADDR == `DFA_ADDR_FLAGS);
endmodule
bind dfa_datapath dfa_datapath_monitor u_mon (.SYS_CLK(SYS_CLK),
	.RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR));

// ### sim/dfa_seq_model.sv
// sequencer model: drives register traffic into the datapath
module dfa_seq_model (
	input  wire logic        clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer; held until ready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // stale data never looks valid
	endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench for the data-format datapath
`include "dfa_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, psel, pen, pwr, prdy, perr, e;
	logic [7:0]  padr;
	logic [31:0] pwd, prd, r0, r1, r2, f;
	int          fail_count;
	int          check_count;
	dfa_datapath dut_u (.SYS_CLK(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));
	dfa_seq_model u_seq (.clk(clk), .prdata(prd), .pready(prdy),
		.pslverr(perr), .psel(psel), .penable(pen), .pwrite(pwr),
		.paddr(padr), .pwdata(pwd));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string n, input logic [31:0] s, x);
		check_count++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_seq.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		u_seq.xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask
	// loads operands, starts op, polls busy, fetches results
	task automatic run(input dfa_pkg::dfa_op_e op,
		input logic [15:0] a, b, c);
		wr(`DFA_ADDR_OPA, a);
		wr(`DFA_ADDR_OPB, b);
		wr(`DFA_ADDR_OPC, c);
		wr(`DFA_ADDR_RES2, 16'h0000);
		wr(`DFA_ADDR_CMD, op);
		f = 32'h0000_0010;
		for (int i = 0; i < 80 && f[4] !== 1'b0; i++)
			rd(`DFA_ADDR_FLAGS, f);
		rd(`DFA_ADDR_RES0, r0);
		rd(`DFA_ADDR_RES1, r1);
		rd(`DFA_ADDR_RES2, r2);
	endtask
	task automatic t_bus;
		rd(`DFA_ADDR_FLAGS, f);
		check("flags", f, 8'h08);
		wr(`DFA_ADDR_RES0, 16'h1234);
		rd(`DFA_ADDR_RES0, r0);
		check("res0", r0, 8'h00);
		rd(8'h20, r0);
		check("err", e, 1'b1);
		check("rdata", r0, 8'h00);
		$display("bus done");
	endtask
	task automatic t_add;
		run(dfa_pkg::OP_SIGNED_ADD, 16'h7FFF, 16'h0001, 16'h0000);
		check("sadd", r0, 16'h8000);
		check("sflg", f, 8'h06);
		run(dfa_pkg::OP_UNSIGNED_ADD, 16'hFFFF, 16'h0001, 16'h0000);
		check("uadd", r0, 16'h0000);
		check("uflg", f, 8'h0B);
		run(dfa_pkg::OP_SIGNED_SUBTRACT, 16'h8000, 16'h0001, 16'h0000);
		check("ssub", f, 8'h03);
		run(dfa_pkg::OP_UNSIGNED_SUBTRACT, 16'h0003, 16'h0005, 16'h0000);
		check("usub", r0, 16'hFFFE);
		check("ulow", f, 8'h06);
		run(dfa_pkg::OP_UNSIGNED_SUBTRACT, 16'h0005, 16'h0003, 16'h0000);
		check("uhi", f, 8'h03);
		run(dfa_pkg::OP_UNSIGNED_COMPARE, 16'h8000, 16'h0001, 16'h0000);
		check("ucmp", f[3:2], 2'h0);
		$display("add done");
	endtask
	task automatic t_muldiv;
		run(dfa_pkg::OP_UNSIGNED_MULTIPLY, 16'hFFFF, 16'h0002, 16'h0000);
		check("umlo", r0, 16'hFFFE);
		check("umhi", r1, 16'h0001);
		check("umc", f[0], 1'b1);
		run(dfa_pkg::OP_SIGNED_MULTIPLY, 16'h0100, 16'h0100, 16'h0000);
		check("smov", f[1], 1'b1);
		run(dfa_pkg::OP_WIDENING_MULTIPLY, 16'hFFFF, 16'h0002, 16'h0000);
		check("wmsw", r0, 16'hFFFF);
		check("wlsw", r1, 16'hFFFE);
		check("wov", f[1], 1'b0);
		run(dfa_pkg::OP_UNSIGNED_DIVIDE, 16'h0001, 16'h0000, 16'h0002);
		check("udq", r0, 16'h8000);
		check("udov", f[1], 1'b0);
		run(dfa_pkg::OP_UNSIGNED_DIVIDE, 16'h0002, 16'h0003, 16'h0001);
		check("udw", r0, 16'h0003);
		check("udwo", f[1], 1'b1);
		run(dfa_pkg::OP_SIGNED_DIVIDE, 16'h8000, 16'hFFFF, 16'h0000);
		check("sdov", f[1], 1'b1);
		run(dfa_pkg::OP_WIDE_DIVIDEND_DIV, 16'hFFFF, 16'hFFFE, 16'h0002);
		check("wdq", r0, 16'hFFFF);
		$display("muldiv done");
	endtask
	task automatic t_float;
		run(dfa_pkg::OP_FLOAT_SUM, 16'h4000, 16'h0000, 16'h4000);
		check("fs0", r0, 16'h4040);
		check("fs1", r1, 16'h0000);
		run(dfa_pkg::OP_FLOAT_PRODUCT, 16'h7FC0, 16'h0000, 16'h7FC0);
		check("fpov", f[1], 1'b1);
		run(dfa_pkg::OP_FLOAT_SUM, 16'h0000, 16'h0000, 16'h0000);
		check("fz", r0, 16'h0000);
		check("fzcc", f[3:2], 2'h2);
		run(dfa_pkg::OP_FLOAT_TO_INT_TRNC, 16'h4040, 16'h0000, 16'h0000);
		check("fix", r0, 16'h0002);
		run(dfa_pkg::OP_EXT_FLOAT_NORM, 16'h4000, 16'h0000, 16'h0000);
		check("x", r0 | r1 | r2, 16'h0000);
		run(dfa_pkg::OP_EXT_FLOAT_NORM, 16'h4000, 16'h0000, 16'h0003);
		check("xn", r0, 16'h36E0);
		run(dfa_pkg::OP_FLOAT_QUOTIENT, 16'h4080, 16'h0000, 16'h4040);
		check("fq", r0, 16'h4040);
		$display("float done");
	endtask
	task automatic t_byte;
		run(dfa_pkg::OP_BYTE_FETCH, 16'h0004, 16'h1234, 16'h0000);
		check("bhi", r0, 16'h0012);
		check("bwa", r1, 16'h0002);
		run(dfa_pkg::OP_BYTE_FETCH, 16'h0005, 16'h1234, 16'h0000);
		check("blo", r0, 16'h0034);
		run(dfa_pkg::OP_BYTE_STORE, 16'h0005, 16'h1234, 16'h00AB);
		check("bst", r0, 16'h12AB);
		$display("byte done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog far beyond the test length
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude();
	end
	initial begin
		fail_count = 0;
		check_count = 0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_bus();
		t_add();
		t_muldiv();
		t_float();
		t_byte();
		conclude();
	end
endmodule
